// ### verilog/ptdsb_top.v
// PHY training debug status bus slice with a small control and status register port
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "ptdsb_map.vh"

//
// Contract
// RULE1: Flag a lane after eight consecutive idle data symbols; useful in idle states.
// RULE2: Upper four bits of every eight-bit per-lane field read zero.
// RULE3: Flag a lane once an idle ordered set is received on it.
// RULE4: Flag a lane whose received training set has PAD as link number.
// RULE5: Flag a lane whose received training set has PAD as lane number.
// RULE6: Count consecutive identical training sets since state entry; wrap after maximum.
// RULE7: Take the identical count from logical lane zero, following lane reversal.
// RULE8: Report configured lanes one-hot: 0001 one, 0010 two, 0100 four.
// RULE9: Expose three-bit deskew FIFO fill per physical lane, lane zero lowest.
// RULE10: Set a per-lane error flag whenever that lane's deskew FIFO overflows.
// RULE11: A deskew overflow is a receive port error and starts link retraining.
// RULE12: Expose four-bit elastic buffer fill for lanes zero and one.
// RULE13: With an external PIPE PHY, elastic fill and receive status mean nothing.
// RULE14: Lane zero receive status uses the eight-entry PIPE status code.
// RULE15: Lane zero polarity bit shows the request to invert received data.
// RULE16: Received training set flags clear whenever training enters a new state.
// RULE17: All slice fields are registered on the core clock, reset to zero.
module ptdsb_top (
  // Clock and reset
  input  wire                                    mclk,
  input  wire                                    rstn,
  // Register port
  input  wire [`PTDSB_ADDR_W-1:0]                regAddr,
  input  wire [31:0]                             regWrData,
  input  wire                                    regWrStrobe,
  input  wire                                    regRdStrobe,
  output reg  [31:0]                             regRdData_reg,
  // Training state machine
  input  wire [`PTDSB_STATE_W-1:0]               ltssmState,
  input  wire                                    linkTrained,
  input  wire [1:0]                              trainedWidth,
  input  wire                                    laneReversed,
  // Per-lane receive events, bit n is physical lane n
  input  wire [`PTDSB_LANES-1:0]                 symValid,
  input  wire [`PTDSB_LANES-1:0]                 symIsIdle,
  input  wire [`PTDSB_LANES-1:0]                 idleOsSeen,
  input  wire [`PTDSB_LANES-1:0]                 tsSeen,
  input  wire [`PTDSB_LANES-1:0]                 tsIsSecond,
  input  wire [`PTDSB_LANES-1:0]                 tsLinkPad,
  input  wire [`PTDSB_LANES-1:0]                 tsLanePad,
  input  wire [`PTDSB_LANES*`PTDSB_TSPARAM_W-1:0] tsParams,
  // Deskew FIFOs
  input  wire [`PTDSB_LANES*`PTDSB_DESKEW_W-1:0] deskewFill,
  input  wire [`PTDSB_LANES-1:0]                 deskewOverflow,
  // Coding sublayer, lanes zero and one
  input  wire [`PTDSB_ELASTIC_W-1:0]             elasticFillLaneA,
  input  wire [`PTDSB_ELASTIC_W-1:0]             elasticFillLaneB,
  input  wire [`PTDSB_RXCOND_W-1:0]              laneAReceiveCondition,
  input  wire                                    laneAInvertRequest,
  // Debug outputs
  output reg  [`PTDSB_SLICE_W-1:0]               debugSlice_reg,
  output reg  [`PTDSB_ELASTIC_W-1:0]             elasticFillLaneBOut_reg,
  output reg                                     retrainRequest_reg
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Width code 1 = x1, 2 = x2, 3 = x4; nothing before training ends
  function [3:0] laneOneHot;
    input       trained;
    input [1:0] width;
    begin
      if (!trained) begin
        laneOneHot = `PTDSB_LANES_NONE;
      end else begin
        case (width)
          2'h1:    laneOneHot = `PTDSB_LANES_X1;
          2'h2:    laneOneHot = `PTDSB_LANES_X2;
          2'h3:    laneOneHot = `PTDSB_LANES_X4;
          default: laneOneHot = `PTDSB_LANES_NONE;
        endcase
      end
    end
  endfunction

  // Physical lane carrying logical lane zero; reversal maps it to the top lane
  function [1:0] logicalZeroLane;
    input       reversed;
    input [1:0] width;
    begin
      if (!reversed) begin
        logicalZeroLane = 2'h0;
      end else begin
        case (width)
          2'h2:    logicalZeroLane = 2'h1;
          2'h3:    logicalZeroLane = 2'h3;
          default: logicalZeroLane = 2'h0;
        endcase
      end
    end
  endfunction

  // Pad a four-lane flag vector into an eight-bit per-lane field
  function [7:0] laneField;
    input [3:0] flags;
    begin
      laneField = {4'h0, flags};
    end
  endfunction

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  reg  [`PTDSB_STATE_W-1:0]  prevState_reg;
  reg                        externalPhy_reg;
  reg  [`PTDSB_LANES-1:0]    deskewError_reg;
  reg  [`PTDSB_LANES-1:0]    deskewError_next;
  reg  [31:0]                rdValue;
  reg  [`PTDSB_SLICE_W-1:0]  debugSlice_next;
  wire                       stateEntry;
  wire [`PTDSB_LANES-1:0]    eightIdle;
  wire [`PTDSB_LANES-1:0]    idleOsFlag;
  wire [`PTDSB_LANES-1:0]    linkPadFlag;
  wire [`PTDSB_LANES-1:0]    lanePadFlag;
  wire [`PTDSB_LANES-1:0]    firstTsFlag;
  wire [`PTDSB_LANES-1:0]    secondTsFlag;
  wire [1:0]                 zeroLane;
  wire                       zeroTsSeen;
  wire [`PTDSB_TSPARAM_W-1:0] zeroTsParams;
  wire [7:0]                 identicalCount;
  wire [3:0]                 lanesOneHot;
  wire                       wrErr;
  genvar                     lane;

  // ------------------------------------------------------------------
  // State entry detection
  // ------------------------------------------------------------------

  // Any change of state code is an entry; the pulse lines up with the first
  // cycle in the new state, so an event there still sets its flag
  assign stateEntry = (ltssmState != prevState_reg);

  always @(posedge mclk) begin
    if (!rstn) begin
      prevState_reg <= {`PTDSB_STATE_W{1'b0}};
    end else begin
      prevState_reg <= ltssmState;
    end
  end

  // ------------------------------------------------------------------
  // Per-lane flag monitors
  // ------------------------------------------------------------------
  generate
    for (lane = 0; lane < `PTDSB_LANES; lane = lane + 1) begin : gLane
      ptdsb_lane_mon uMon (
        .mclk                      (mclk),
        .rstn                      (rstn),
        .stateEntry                (stateEntry),
        .symValid                  (symValid[lane]),
        .symIsIdle                 (symIsIdle[lane]),
        .idleOsSeen                (idleOsSeen[lane]),
        .tsSeen                    (tsSeen[lane]),
        .tsIsSecond                (tsIsSecond[lane]),
        .tsLinkPad                 (tsLinkPad[lane]),
        .tsLanePad                 (tsLanePad[lane]),
        .eightIdleSymbolsSeen_reg  (eightIdle[lane]),
        .idleOsFlag_reg            (idleOsFlag[lane]),
        .linkPadFlag_reg           (linkPadFlag[lane]),
        .lanePadFlag_reg           (lanePadFlag[lane]),
        .firstTrainingSetSeen_reg  (firstTsFlag[lane]),
        .secondTrainingSetSeen_reg (secondTsFlag[lane])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Identical training set count on logical lane zero
  // ------------------------------------------------------------------
  assign zeroLane     = logicalZeroLane(laneReversed, trainedWidth); // RULE7
  assign zeroTsSeen   = tsSeen[zeroLane]; // RULE7
  assign zeroTsParams = tsParams[zeroLane*`PTDSB_TSPARAM_W +: `PTDSB_TSPARAM_W]; // RULE7

  // Reversal changing mid-state would merge two lanes' runs; it only moves
  // during configuration, where a state change restarts the count anyway
  ptdsb_ts_count uTsCount (
    .mclk               (mclk),
    .rstn               (rstn),
    .stateEntry         (stateEntry),
    .tsSeen             (zeroTsSeen),
    .tsParams           (zeroTsParams),
    .identicalCount_reg (identicalCount)
  );

  assign lanesOneHot = laneOneHot(linkTrained, trainedWidth); // RULE8

  // ------------------------------------------------------------------
  // Deskew overflow errors and retrain request
  // ------------------------------------------------------------------

  // Error bits stay until software clears them; retraining changes the
  // state, so clearing on state entry would hide the cause
  assign wrErr = regWrStrobe & (regAddr == `PTDSB_REG_ERR);

  always @* begin
    deskewError_next = deskewError_reg;
    if (wrErr) begin
      deskewError_next = deskewError_reg & ~regWrData[`PTDSB_LANES-1:0];
    end
    deskewError_next = deskewError_next | deskewOverflow; // RULE10
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      deskewError_reg    <= {`PTDSB_LANES{1'b0}};
      retrainRequest_reg <= 1'h0;
    end else begin
      deskewError_reg    <= deskewError_next; // RULE10
      retrainRequest_reg <= |deskewOverflow; // RULE11
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      externalPhy_reg <= `PTDSB_CTRL_RESET;
    end else if (regWrStrobe && regAddr == `PTDSB_REG_CTRL) begin
      externalPhy_reg <= regWrData[`PTDSB_CTRL_EXTPHY];
    end
  end

  // ------------------------------------------------------------------
  // Debug slice assembly
  // ------------------------------------------------------------------

  // Elastic fill and receive status fields are forced to zero with an external PHY rather
  // than passing whatever the unused ports float to
  always @* begin
    debugSlice_next = {`PTDSB_SLICE_W{1'b0}};
    debugSlice_next[`PTDSB_IDLESYM_LSB +: 8] = laneField(eightIdle); // RULE2
    debugSlice_next[`PTDSB_IDLEOS_LSB +: 8]  = laneField(idleOsFlag); // RULE2
    debugSlice_next[`PTDSB_LINKPAD_LSB +: 8] = laneField(linkPadFlag); // RULE2
    debugSlice_next[`PTDSB_LANEPAD_LSB +: 8] = laneField(lanePadFlag); // RULE2
    debugSlice_next[`PTDSB_TSNUM_LSB +: 8]   = identicalCount; // RULE6
    debugSlice_next[`PTDSB_LANES_LSB +: 4]   = lanesOneHot; // RULE8
    debugSlice_next[`PTDSB_DESKEW_LSB +: `PTDSB_LANES*`PTDSB_DESKEW_W] = deskewFill; // RULE9
    debugSlice_next[`PTDSB_DESKERR_LSB +: 8] = laneField(deskewError_reg); // RULE2
    if (!externalPhy_reg) begin
      debugSlice_next[`PTDSB_ELASTIC_LSB +: `PTDSB_ELASTIC_W] = elasticFillLaneA; // RULE12
      debugSlice_next[`PTDSB_RXCOND_LSB +: `PTDSB_RXCOND_W]   = laneAReceiveCondition; // RULE14
    end
    debugSlice_next[`PTDSB_INVERT_BIT] = laneAInvertRequest; // RULE15
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      debugSlice_reg          <= {`PTDSB_SLICE_W{1'b0}}; // RULE17
      elasticFillLaneBOut_reg <= {`PTDSB_ELASTIC_W{1'b0}};
    end else begin
      debugSlice_reg <= debugSlice_next; // RULE17
      if (externalPhy_reg) begin
        elasticFillLaneBOut_reg <= {`PTDSB_ELASTIC_W{1'b0}}; // RULE13
      end else begin
        elasticFillLaneBOut_reg <= elasticFillLaneB; // RULE12
      end
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------

  // Status reads the live registered slice, training set flags straight from the lane monitors
  always @* begin
    rdValue = 32'h0000_0000;
    case (regAddr)
      `PTDSB_REG_CTRL: begin
        rdValue[`PTDSB_CTRL_EXTPHY] = externalPhy_reg;
      end
      `PTDSB_REG_ERR: begin
        rdValue[`PTDSB_LANES-1:0] = deskewError_reg;
      end
      `PTDSB_REG_STAT: begin
        rdValue[3:0]   = debugSlice_reg[`PTDSB_LANES_LSB +: 4];
        rdValue[15:8]  = debugSlice_reg[`PTDSB_TSNUM_LSB +: 8];
        rdValue[18:16] = debugSlice_reg[`PTDSB_RXCOND_LSB +: `PTDSB_RXCOND_W]; // RULE13
        rdValue[19]    = debugSlice_reg[`PTDSB_INVERT_BIT];
        rdValue[27:24] = firstTsFlag; // RULE16
        rdValue[31:28] = secondTsFlag; // RULE16
      end
      default: begin
        rdValue = 32'h0000_0000;
      end
    endcase
  end

  // Read data stand for one cycle only, zero otherwise
  always @(posedge mclk) begin
    if (!rstn) begin
      regRdData_reg <= 32'h0000_0000;
    end else if (regRdStrobe) begin
      regRdData_reg <= rdValue;
    end else begin
      regRdData_reg <= 32'h0000_0000;
    end
  end

endmodule // ptdsb_top

// ### verilog/ptdsb_map.vh
// Constants for the PHY training debug status bus slice: field positions, offsets, resets, counts
`ifndef PTDSB_MAP_VH
`define PTDSB_MAP_VH

// ------------------------------------------------------------------
// Slice geometry, positions relative to bit 368 of the test bus
// ------------------------------------------------------------------
`define PTDSB_SLICE_W        88
`define PTDSB_IDLESYM_LSB    0
`define PTDSB_IDLEOS_LSB     8
`define PTDSB_LINKPAD_LSB    16
`define PTDSB_LANEPAD_LSB    24
`define PTDSB_TSNUM_LSB      32
`define PTDSB_LANES_LSB      40
`define PTDSB_DESKEW_LSB     48
`define PTDSB_DESKERR_LSB    72
`define PTDSB_ELASTIC_LSB    80
`define PTDSB_RXCOND_LSB     84
`define PTDSB_INVERT_BIT     87

// ------------------------------------------------------------------
// Field widths and counts
// ------------------------------------------------------------------
`define PTDSB_LANES          4
`define PTDSB_DESKEW_W       3
`define PTDSB_ELASTIC_W      4
`define PTDSB_RXCOND_W       3
`define PTDSB_TSPARAM_W      16
`define PTDSB_IDLE_RUN       4'h8
`define PTDSB_STATE_W        5

// ------------------------------------------------------------------
// One-hot configured lane codes
// ------------------------------------------------------------------
`define PTDSB_LANES_NONE     4'h0
`define PTDSB_LANES_X1       4'h1
`define PTDSB_LANES_X2       4'h2
`define PTDSB_LANES_X4       4'h4

// ------------------------------------------------------------------
// Register offsets and reset values
// ------------------------------------------------------------------
`define PTDSB_ADDR_W         4
`define PTDSB_REG_CTRL       4'h0
`define PTDSB_REG_ERR        4'h4
`define PTDSB_REG_STAT       4'h8
`define PTDSB_CTRL_RESET     1'h0
`define PTDSB_CTRL_EXTPHY    0

`endif

// ### verilog/ptdsb_lane_mon.v
// Per-lane receive flag monitor for training ordered sets and idle symbols
`timescale 1ns/1ps
`include "ptdsb_map.vh"

module ptdsb_lane_mon (
  // Clock and reset
  input  wire       mclk,
  input  wire       rstn,
  // Training state change
  input  wire       stateEntry,
  // Received symbol and ordered set events
  input  wire       symValid,
  input  wire       symIsIdle,
  input  wire       idleOsSeen,
  input  wire       tsSeen,
  input  wire       tsIsSecond,
  input  wire       tsLinkPad,
  input  wire       tsLanePad,
  // Sticky flags
  output reg        eightIdleSymbolsSeen_reg,
  output reg        idleOsFlag_reg,
  output reg        linkPadFlag_reg,
  output reg        lanePadFlag_reg,
  output reg        firstTrainingSetSeen_reg,
  output reg        secondTrainingSetSeen_reg
);

  reg  [3:0] idleRun_reg;
  wire       runDone;

  assign runDone = symValid & symIsIdle & (idleRun_reg >= (`PTDSB_IDLE_RUN - 4'h1));

  // ------------------------------------------------------------------
  // Idle run counter: a non-idle symbol breaks the run
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      idleRun_reg <= 4'h0;
    end else if (symValid && !symIsIdle) begin
      idleRun_reg <= 4'h0;
    end else if (symValid && idleRun_reg != `PTDSB_IDLE_RUN) begin
      idleRun_reg <= idleRun_reg + 4'h1; // RULE1
    end
  end

  // ------------------------------------------------------------------
  // Flags clear on each new training state; an event in that cycle wins
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      eightIdleSymbolsSeen_reg  <= 1'h0;
      idleOsFlag_reg            <= 1'h0;
      linkPadFlag_reg           <= 1'h0;
      lanePadFlag_reg           <= 1'h0;
      firstTrainingSetSeen_reg  <= 1'h0;
      secondTrainingSetSeen_reg <= 1'h0;
    end else begin
      eightIdleSymbolsSeen_reg  <= runDone | (eightIdleSymbolsSeen_reg & ~stateEntry); // RULE1
      idleOsFlag_reg            <= idleOsSeen | (idleOsFlag_reg & ~stateEntry); // RULE3
      linkPadFlag_reg           <= (tsSeen & tsLinkPad) | (linkPadFlag_reg & ~stateEntry); // RULE4
      lanePadFlag_reg           <= (tsSeen & tsLanePad) | (lanePadFlag_reg & ~stateEntry); // RULE5
      firstTrainingSetSeen_reg  <= (tsSeen & ~tsIsSecond) |
                                   (firstTrainingSetSeen_reg & ~stateEntry); // RULE16
      secondTrainingSetSeen_reg <= (tsSeen & tsIsSecond) |
                                   (secondTrainingSetSeen_reg & ~stateEntry); // RULE16
    end
  end

endmodule // ptdsb_lane_mon

// ### verilog/ptdsb_ts_count.v
// Consecutive identical training set counter for the logical lane zero stream
`timescale 1ns/1ps
`include "ptdsb_map.vh"

module ptdsb_ts_count (
  // Clock and reset
  input  wire                          mclk,
  input  wire                          rstn,
  // Training state change
  input  wire                          stateEntry,
  // Training set from the selected lane
  input  wire                          tsSeen,
  input  wire [`PTDSB_TSPARAM_W-1:0]   tsParams,
  // Count
  output reg  [7:0]                    identicalCount_reg
);

  reg  [`PTDSB_TSPARAM_W-1:0] lastParams_reg;
  reg                         haveLast_reg;

  // ------------------------------------------------------------------
  // Count wraps 0xff to 0x00 by plain 8-bit overflow; a set arriving
  // on the state entry cycle starts the new run at one
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rstn) begin
      identicalCount_reg <= 8'h00;
      lastParams_reg     <= {`PTDSB_TSPARAM_W{1'b0}};
      haveLast_reg       <= 1'h0;
    end else if (tsSeen) begin
      lastParams_reg <= tsParams;
      haveLast_reg   <= 1'h1;
      if (haveLast_reg && !stateEntry && tsParams == lastParams_reg) begin
        identicalCount_reg <= identicalCount_reg + 8'h01; // RULE6
      end else begin
        identicalCount_reg <= 8'h01; // RULE6
      end
    end else if (stateEntry) begin
      identicalCount_reg <= 8'h00; // RULE6
      haveLast_reg       <= 1'h0;
    end
  end

endmodule // ptdsb_ts_count

// ### test/ptdsb_chk.sv
// Concurrent checks on the debug slice and retrain request outputs of ptdsb_top
`timescale 1ns/1ps
module ptdsb_chk (
  // Clock and reset
  input logic        mclk,
  input logic        rstn,
  // Observed inputs
  input logic [4:0]  ltssmState,
  input logic        linkTrained,
  input logic [1:0]  trainedWidth,
  input logic [3:0]  symValid,
  input logic [3:0]  symIsIdle,
  input logic [3:0]  idleOsSeen,
  input logic [3:0]  tsSeen,
  input logic [11:0] deskewFill,
  input logic [3:0]  deskewOverflow,
  input logic        laneAInvertRequest,
  // Observed outputs
  input logic [87:0] debugSlice_reg,
  input logic        retrainRequest_reg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Only four lanes exist, so every upper nibble stays clear
  upper_nibble_zero_a: assert property ({debugSlice_reg[7:4], debugSlice_reg[15:12],
    debugSlice_reg[23:20], debugSlice_reg[31:28], debugSlice_reg[79:76]} == 20'h0)
    else $error("per-lane field upper nibble set");
  lane_code_a: assert property (linkTrained && trainedWidth != 2'h0 |=>
    debugSlice_reg[43:40] == (4'h1 << ($past(trainedWidth) - 2'h1)))
    else $error("configured lane code wrong");
  deskew_fill_a: assert property (1'b1 |=> debugSlice_reg[59:48] == $past(deskewFill))
    else $error("deskew fill not passed through");
  retrain_pulse_a: assert property (|deskewOverflow |=> retrainRequest_reg)
    else $error("overflow did not request retraining");
  deskew_err_a: assert property (deskewOverflow[2] |-> ##[1:2] debugSlice_reg[74])
    else $error("deskew error flag missing");
  invert_pass_a: assert property (1'b1 |=> debugSlice_reg[87] == $past(laneAInvertRequest))
    else $error("invert request not passed through");
  // Gaps in symValid are not counted, so the run is written on consecutive symbols
  idle_run_a: assert property ((symValid[0] && symIsIdle[0] && $stable(ltssmState))[*8]
    |-> ##2 debugSlice_reg[0]) else $error("eight idle symbols not flagged");
  state_clear_a: assert property ($changed(ltssmState) && tsSeen == 4'h0 &&
    idleOsSeen == 4'h0 |-> ##2 debugSlice_reg[39:8] == 32'h0)
    else $error("flags or count survive state entry");
endmodule // ptdsb_chk

bind ptdsb_top ptdsb_chk i_chk (.mclk(mclk), .rstn(rstn), .ltssmState(ltssmState),
  .linkTrained(linkTrained), .trainedWidth(trainedWidth), .symValid(symValid),
  .symIsIdle(symIsIdle), .idleOsSeen(idleOsSeen), .tsSeen(tsSeen), .deskewFill(deskewFill),
  .deskewOverflow(deskewOverflow), .laneAInvertRequest(laneAInvertRequest),
  .debugSlice_reg(debugSlice_reg), .retrainRequest_reg(retrainRequest_reg));

// ### test/ptdsb_probe.sv
// Debug-side probe model that samples the slice as a logic analyser would
`timescale 1ns/1ps
module ptdsb_probe (
  // Clock
  input logic        mclk,
  // Observed slice
  input logic [87:0] debugSlice_reg,
  // Captured fields
  output logic [7:0] tsCount,
  output logic [3:0] laneCode
);
  // A probe only sees settled values, so it captures one edge late
  always_ff @(posedge mclk) begin
    tsCount  <= debugSlice_reg[39:32];
    laneCode <= debugSlice_reg[43:40];
  end
endmodule // ptdsb_probe

// ### test/tb_top.sv
// Self-checking testbench for the training debug status slice
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  regAddr = 4'h0, symValid = 4'h0, symIsIdle = 4'h0, idleOsSeen = 4'h0;
  logic [31:0] regWrData = 32'h0, regRdData_reg;
  logic        regWrStrobe = 1'b0, regRdStrobe = 1'b0, linkTrained = 1'b0;
  logic        laneReversed = 1'b0, laneAInvertRequest = 1'b0, retrainRequest_reg;
  logic [4:0]  ltssmState = 5'h0;
  logic [1:0]  trainedWidth = 2'h0;
  logic [3:0]  tsSeen = 4'h0, tsIsSecond = 4'h0, tsLinkPad = 4'h0, tsLanePad = 4'h0;
  logic [63:0] tsParams = 64'h0;
  logic [11:0] deskewFill = 12'h0;
  logic [3:0]  deskewOverflow = 4'h0, elasticFillLaneA = 4'h0, elasticFillLaneB = 4'h0;
  logic [2:0]  laneAReceiveCondition = 3'h0;
  logic [87:0] debugSlice_reg;
  logic [3:0]  elasticFillLaneBOut_reg, laneCode;
  logic [7:0]  tsCount;
  int          n_errors = 0;
  int          compares = 0;

  // Free-running 10 MHz core clock
  always #50 mclk = ~mclk;

  ptdsb_top i_dut (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData_reg(regRdData_reg),
    .ltssmState(ltssmState), .linkTrained(linkTrained), .trainedWidth(trainedWidth),
    .laneReversed(laneReversed), .symValid(symValid), .symIsIdle(symIsIdle),
    .idleOsSeen(idleOsSeen), .tsSeen(tsSeen), .tsIsSecond(tsIsSecond), .tsLinkPad(tsLinkPad),
    .tsLanePad(tsLanePad), .tsParams(tsParams), .deskewFill(deskewFill),
    .deskewOverflow(deskewOverflow), .elasticFillLaneA(elasticFillLaneA),
    .elasticFillLaneB(elasticFillLaneB), .laneAReceiveCondition(laneAReceiveCondition),
    .laneAInvertRequest(laneAInvertRequest), .debugSlice_reg(debugSlice_reg),
    .elasticFillLaneBOut_reg(elasticFillLaneBOut_reg), .retrainRequest_reg(retrainRequest_reg));
  ptdsb_probe i_probe (.mclk(mclk), .debugSlice_reg(debugSlice_reg), .tsCount(tsCount),
    .laneCode(laneCode));

  // Helpers: wait edges, compare, register cycles, verdict
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task chk(input string nm, input logic [87:0] e, input logic [87:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge mclk);
    regWrStrobe <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge mclk);
    regRdStrobe <= 1'b0;
    #1 chk(nm, e, regRdData_reg);
  endtask
  task done(input string t);
    $display("test %s done", t);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc(3);
    rstn <= 1'b1;
    cyc(1);
    #1 chk("slice", 88'h0, debugSlice_reg);
    rd(4'h0, 32'h0, "ctrl");
    done("reset");
    for (int w = 1; w < 4; w++) begin
      @(posedge mclk);
      linkTrained <= 1'b1;
      trainedWidth <= w[1:0];
      cyc(3);
      #1 chk("lane code", 4'h1 << (w - 1), laneCode);
    end
    done("lanes");
    // Non-idle symbol breaks the run; an empty cycle does not
    @(posedge mclk);
    ltssmState <= 5'h0e;
    symValid <= 4'h1;
    symIsIdle <= 4'h1;
    cyc(7);
    symIsIdle <= 4'h0;
    cyc(1);
    symIsIdle <= 4'h1;
    cyc(7);
    symValid <= 4'h0;
    cyc(2);
    #1 chk("idle short", 8'h0, debugSlice_reg[7:0]);
    @(posedge mclk);
    symValid <= 4'h1;
    cyc(2);
    #1 chk("idle gap", 8'h1, debugSlice_reg[7:0]);
    cyc(6);
    symValid <= 4'h0;
    cyc(2);
    #1 chk("idle run", 8'h1, debugSlice_reg[7:0]);
    done("idle");
    @(posedge mclk);
    tsSeen <= 4'h4;
    tsLinkPad <= 4'h4;
    tsLanePad <= 4'h4;
    idleOsSeen <= 4'h8;
    @(posedge mclk);
    tsSeen <= 4'h0;
    tsLinkPad <= 4'h0;
    tsLanePad <= 4'h0;
    idleOsSeen <= 4'h0;
    cyc(2);
    #1 chk("idle os", 8'h08, debugSlice_reg[15:8]);
    chk("link pad", 8'h04, debugSlice_reg[23:16]);
    chk("lane pad", 8'h04, debugSlice_reg[31:24]);
    @(posedge mclk);
    ltssmState <= 5'h0d;
    cyc(2);
    #1 chk("cleared", 24'h0, debugSlice_reg[31:8]);
    done("flags");
    @(posedge mclk);
    tsParams <= 64'h1234;
    tsSeen <= 4'h1;
    cyc(3);
    tsSeen <= 4'h0;
    cyc(2);
    #1 chk("same ts", 8'h3, debugSlice_reg[39:32]);
    @(posedge mclk);
    tsParams <= 64'h5678;
    tsSeen <= 4'h1;
    @(posedge mclk);
    tsSeen <= 4'h0;
    cyc(2);
    #1 chk("new ts", 8'h1, debugSlice_reg[39:32]);
    // Reversed x4 link counts physical lane three; 258 sets wrap once
    @(posedge mclk);
    laneReversed <= 1'b1;
    ltssmState <= 5'h0c;
    cyc(2);
    tsParams <= 64'h00aa_0000_0000_0000;
    tsSeen <= 4'h8;
    tsIsSecond <= 4'h8;
    cyc(258);
    tsSeen <= 4'h0;
    cyc(3);
    #1 chk("wrap", 8'h2, tsCount);
    done("count");
    @(posedge mclk);
    deskewFill <= 12'hc53;
    deskewOverflow <= 4'h4;
    @(posedge mclk);
    deskewOverflow <= 4'h0;
    #1 chk("retrain", 1'b1, retrainRequest_reg);
    cyc(1);
    #1 chk("retrain end", 1'b0, retrainRequest_reg);
    cyc(1);
    #1 chk("fills", 12'hc53, debugSlice_reg[59:48]);
    chk("deskew err", 8'h04, debugSlice_reg[79:72]);
    rd(4'h4, 32'h4, "err reg");
    wr(4'h4, 32'h4);
    rd(4'h4, 32'h0, "err clear");
    done("deskew");
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk);
      laneAReceiveCondition <= c[2:0];
      cyc(2);
      #1 chk("rx cond", c[2:0], debugSlice_reg[86:84]);
    end
    @(posedge mclk);
    elasticFillLaneA <= 4'h9;
    elasticFillLaneB <= 4'h5;
    laneAReceiveCondition <= 3'h5;
    laneAInvertRequest <= 1'b1;
    wr(4'h0, 32'h1);
    cyc(2);
    #1 chk("ext phy", 8'h80, debugSlice_reg[87:80]);
    chk("ext phy b", 4'h0, elasticFillLaneBOut_reg);
    wr(4'h0, 32'h0);
    cyc(2);
    #1 chk("int phy", 8'hd9, debugSlice_reg[87:80]);
    chk("fill b", 4'h5, elasticFillLaneBOut_reg);
    rd(4'hc, 32'h0, "unmapped");
    rd(4'h8, 32'h800d_0204, "status");
    done("pcs");
    tally_and_finish;
  end
endmodule // tb_top
